// ---- src/oms_maint_gen_det.sv ----
// Purpose: OTN maintenance signal insertion and detection
// Assumes: byte stream with flags marking FA OH and OTU OH bytes
// Notes: one ODU instance per byte lane; ODUCn lanes set by instance
//
// Overview of operation
// R01 - Upstream defect forces ODU-AIS; detected AIS suppresses signal fail, not the LOS defect.
// R02 - Unconnected output point gets OCI inserted.
// R03 - Sink detects OCI to tell opened connection from a defect.
// R04 - Administrative lock sends LCK downstream instead of traffic.
// R05 - Payload missing indication suppresses loss-of-signal defect.
// R06 - Terminated OTU with server forward defect sends ODU-AIS.
// R07 - Unterminated OTUCn with server forward defect sends OTUCn-AIS.
// R08 - OTUk-AIS is free-running PN-11 across frame boundaries.
// R09 - OTUk-AIS detected but optional to generate; never for OTU0.
// R10 - OTUCn-AIS is all ones except frame alignment overhead.
// R11 - OTUCn-AIS detected from SM status bits.
// R12 - ODU-AIS is all ones except FA and OTU overhead.
// R13 - ODUCn carries n AIS instances; ODUk carries one.
// R14 - Detection relies only on status fields, tolerating added overhead.
// R15 - ODU-AIS recognised from PM and TCM status bits.
// R16 - OCI fills 0x66 pattern or other with status 110; not ODUCn.
// R17 - ODUk-OCI recognised from PM and TCM status bits.
// R18 - LCK fills 0x55 pattern or other with status 101.
// R19 - ODU-LCK recognised from PM and TCM status bits.
// R20 - Generic-AIS is 2047-bit sequence from 1 + x^9 + x^11.
// R21 - PN-11 register seeded non-zero and free-running.
`timescale 1ns/1ps
module oms_maint_gen_det
#(
   parameter int N_INST = 1,
   parameter logic [7:0] OCI_PAT = oms_pkg::OCI_BYTE,
   parameter logic [7:0] LCK_PAT = oms_pkg::LCK_BYTE,
   parameter bit GEN_OTUK_AIS = 1'b1
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] inData,
   input wire logic inValid,
   input wire logic inFaOh,
   input wire logic inOtuOh,
   input wire logic isCn,
   input wire logic isOtu0,
   input wire logic otuTerminated,
   input wire logic upstreamDefect,
   input wire logic serverFdi,
   input wire logic notConnected,
   input wire logic adminLock,
   input wire logic useGenericAis,
   input wire logic pmiIn,
   input wire logic losIn,
   input wire logic [N_INST-1:0] instSel,
   input wire logic statValid,
   input wire logic [2:0] smStat,
   input wire logic [2:0] pmStat,
   input wire logic [3*oms_pkg::TCM_N-1:0] tcmStat,
   input wire logic pnCheckValid,
   input wire logic pnMatch,
   output logic [7:0] outData,
   output logic outValid,
   output logic [2:0] modeOut,
   output logic aisDet,
   output logic ociDet,
   output logic lckDet,
   output logic otucAisDet,
   output logic otukAisDet,
   output logic losDefect,
   output logic signalFail
);
   localparam int NDET = oms_pkg::TCM_N + 2;

   function automatic logic isCode(input logic [2:0] s, input logic [2:0] c);
      return s == c;
   endfunction

   // Bytes that a maintenance fill other than OTUCn-AIS may replace
   function automatic logic isPay(input logic fa, input logic otu);
      return !fa && !otu;
   endfunction

   oms_pkg::oms_mode_e mode_reg;
   oms_pkg::oms_mode_e mode_next;
   logic [7:0] data_reg;
   logic [7:0] data_next;
   logic valid_reg;
   logic valid_next;
   logic [7:0] pnByte;
   logic pnAdvance;
   logic [2:0] acc [NDET];
   logic [2:0] rawStat [NDET];
   logic ais_reg;
   logic ais_next;
   logic oci_reg;
   logic oci_next;
   logic lck_reg;
   logic lck_next;
   logic otuc_reg;
   logic otuc_next;
   logic otuk_reg;
   logic otuk_next;
   logic los_reg;
   logic los_next;
   logic sf_reg;
   logic sf_next;
   logic [1:0] pnCnt_reg;
   logic [1:0] pnCnt_next;

   assign rawStat[0] = smStat;
   assign rawStat[1] = pmStat;

   genvar g;
   generate
      for (g = 0; g < oms_pkg::TCM_N; g++)
      begin : gTcm
         assign rawStat[g + 2] = tcmStat[3*g +: 3];
      end
      for (g = 0; g < NDET; g++)
      begin : gDet
         oms_stat_det uDet
         (
            .clk(clk),
            .arst_n(arst_n),
            .statValid(statValid),
            .statIn(rawStat[g]),
            .statAccepted(acc[g])
         );
      end
   endgenerate

   // Generic-AIS byte source, advanced only on bytes it fills
   assign pnAdvance = inValid && mode_next == oms_pkg::OMS_GAIS &&
                      isPay(inFaOh, inOtuOh);

   oms_pn11 uPn
   (
      .clk(clk),
      .arst_n(arst_n),
      .advance(pnAdvance),
      .pnByte(pnByte)
   );

   // Insertion mode, highest priority first
   always_comb
   begin
      mode_next = oms_pkg::OMS_PASS;
      if (serverFdi && isCn && !otuTerminated)
      begin
         mode_next = oms_pkg::OMS_OTUC_AIS; // R07
      end
      else if (serverFdi || upstreamDefect)
      begin
         mode_next = oms_pkg::OMS_ODU_AIS; // R01 R06
      end
      else if (useGenericAis && GEN_OTUK_AIS && !isCn && !isOtu0)
      begin
         mode_next = oms_pkg::OMS_GAIS; // R09
      end
      else if (adminLock)
      begin
         mode_next = oms_pkg::OMS_LCK; // R04
      end
      else if (notConnected && !isCn)
      begin
         mode_next = oms_pkg::OMS_OCI; // R02 R16
      end
   end

   // Byte replacement; instSel picks ODUCn instances
   always_comb
   begin
      logic hit;
      logic pay;
      hit = isCn ? |instSel : 1'b1; // R13
      pay = isPay(inFaOh, inOtuOh);
      data_next = inData;
      valid_next = inValid;
      case (mode_next)
         oms_pkg::OMS_OTUC_AIS:
            if (!inFaOh)
            begin
               data_next = oms_pkg::AIS_BYTE; // R10
            end
         oms_pkg::OMS_ODU_AIS:
            if (pay && hit)
            begin
               data_next = oms_pkg::AIS_BYTE; // R12
            end
         oms_pkg::OMS_LCK:
            if (pay && hit)
            begin
               data_next = LCK_PAT; // R18
            end
         oms_pkg::OMS_OCI:
            if (pay)
            begin
               data_next = OCI_PAT; // R16
            end
         oms_pkg::OMS_GAIS:
            if (pay)
            begin
               data_next = pnByte; // R08 R20
            end
         oms_pkg::OMS_PASS:
            data_next = inData;
         default:
            data_next = inData;
      endcase
   end

   // AIS, OCI and LCK detection purely from status fields; OTUk-AIS from the PN match inputs
   // Added TCM, GCC or APS overhead thus cannot hide a signal
   always_comb
   begin
      ais_next = 1'b0;
      oci_next = 1'b0;
      lck_next = 1'b0;
      for (int i = 1; i < NDET; i++)
      begin
         ais_next |= isCode(acc[i], oms_pkg::STAT_AIS); // R15 R14
         oci_next |= isCode(acc[i], oms_pkg::STAT_OCI) && !isCn; // R17 R03
         lck_next |= isCode(acc[i], oms_pkg::STAT_LCK); // R19
      end
      otuc_next = isCn && isCode(acc[0], oms_pkg::STAT_AIS); // R11
      pnCnt_next = pnCnt_reg;
      otuk_next = otuk_reg;
      if (pnCheckValid)
      begin
         if (!pnMatch)
         begin
            pnCnt_next = 2'h0;
         end
         else if (pnCnt_reg != 2'(oms_pkg::PN_MATCH_CNT - 1))
         begin
            pnCnt_next = pnCnt_reg + 2'h1;
         end
         otuk_next = pnMatch &&
                     pnCnt_reg == 2'(oms_pkg::PN_MATCH_CNT - 1); // R09
      end
      if (isCn || isOtu0)
      begin
         otuk_next = 1'b0; // R09
      end
      los_next = losIn && !pmiIn; // R05
      sf_next = (losIn && !pmiIn) && !(ais_next || otuc_next); // R01
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_reg <= oms_pkg::OMS_PASS;
         data_reg <= 8'h00;
         valid_reg <= 1'b0;
         ais_reg <= 1'b0;
         oci_reg <= 1'b0;
         lck_reg <= 1'b0;
         otuc_reg <= 1'b0;
         otuk_reg <= 1'b0;
         los_reg <= 1'b0;
         sf_reg <= 1'b0;
         pnCnt_reg <= 2'h0;
      end
      else
      begin
         mode_reg <= mode_next;
         data_reg <= data_next;
         valid_reg <= valid_next;
         ais_reg <= ais_next;
         oci_reg <= oci_next;
         lck_reg <= lck_next;
         otuc_reg <= otuc_next;
         otuk_reg <= otuk_next;
         los_reg <= los_next;
         sf_reg <= sf_next;
         pnCnt_reg <= pnCnt_next;
      end
   end

   assign outData = data_reg;
   assign outValid = valid_reg;
   assign modeOut = mode_reg;
   assign aisDet = ais_reg;
   assign ociDet = oci_reg;
   assign lckDet = lck_reg;
   assign otucAisDet = otuc_reg;
   assign otukAisDet = otuk_reg;
   assign losDefect = los_reg;
   assign signalFail = sf_reg;
endmodule

// ---- src/oms_pkg.sv ----
// Purpose: shared constants for the OTN maintenance signal block
// Assumes: byte-wide frame stream with overhead-position flags
// Notes: status codes are the 3-bit STAT field values
package oms_pkg;
   localparam int DATA_W = 8;
   localparam int STAT_W = 3;
   localparam int PN_W = 11;
   localparam int PN_TAP_A = 9;
   localparam int PN_TAP_B = 11;
   localparam logic [10:0] PN_SEED = 11'h7FF;
   localparam logic [7:0] AIS_BYTE = 8'hFF;
   localparam logic [7:0] OCI_BYTE = 8'h66;
   localparam logic [7:0] LCK_BYTE = 8'h55;
   localparam logic [2:0] STAT_AIS = 3'h7;
   localparam logic [2:0] STAT_OCI = 3'h6;
   localparam logic [2:0] STAT_LCK = 3'h5;
   localparam int TCM_N = 6;
   localparam int DET_CNT = 3;
   localparam int PN_MATCH_CNT = 4;
   typedef enum logic [2:0] {
      OMS_PASS,
      OMS_ODU_AIS,
      OMS_OCI,
      OMS_LCK,
      OMS_GAIS,
      OMS_OTUC_AIS
   } oms_mode_e;
endpackage

// ---- src/oms_pn11.sv ----
// Purpose: PN-11 generic-AIS byte generator
// Assumes: advance asserted once per payload byte emitted
// Notes: runs across frames, never realigned; pnByte is the next byte
`timescale 1ns/1ps
module oms_pn11
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic advance,
   output logic [7:0] pnByte
);
   logic [10:0] lfsr_reg;
   logic [10:0] lfsr_next;
   logic [7:0] byte_next;

   always_comb
   begin
      logic [10:0] s;
      s = lfsr_reg;
      byte_next = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         byte_next[7 - i] = s[oms_pkg::PN_TAP_B - 1];
         s = {s[9:0], s[oms_pkg::PN_TAP_B - 1] ^ s[oms_pkg::PN_TAP_A - 1]};
      end
      lfsr_next = advance ? s : lfsr_reg; // R20 R08
      if (lfsr_next == 11'h000)
      begin
         lfsr_next = oms_pkg::PN_SEED; // R21
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lfsr_reg <= oms_pkg::PN_SEED; // R21
      end
      else
      begin
         lfsr_reg <= lfsr_next;
      end
   end

   // Current state's byte, so the first fill is already sequence bits
   assign pnByte = byte_next;
endmodule

// ---- src/oms_stat_det.sv ----
// Purpose: persistent STAT code detector for one overhead field
// Assumes: statValid pulses once per frame with a fresh field
// Notes: a code is accepted after DET_CNT equal frames
`timescale 1ns/1ps
module oms_stat_det
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic statValid,
   input wire logic [2:0] statIn,
   output logic [2:0] statAccepted
);
   logic [2:0] last_reg;
   logic [2:0] last_next;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic [2:0] acc_reg;
   logic [2:0] acc_next;

   always_comb
   begin
      last_next = last_reg;
      cnt_next = cnt_reg;
      acc_next = acc_reg;
      if (statValid)
      begin
         last_next = statIn;
         if (statIn != last_reg)
         begin
            cnt_next = 2'h1;
         end
         else if (cnt_reg != 2'(oms_pkg::DET_CNT))
         begin
            cnt_next = cnt_reg + 2'h1;
         end
         if (statIn == last_reg && cnt_reg == 2'(oms_pkg::DET_CNT - 1))
         begin
            acc_next = statIn;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         last_reg <= 3'h0;
         cnt_reg <= 2'h0;
         acc_reg <= 3'h0;
      end
      else
      begin
         last_reg <= last_next;
         cnt_reg <= cnt_next;
         acc_reg <= acc_next;
      end
   end

   assign statAccepted = acc_reg;
endmodule

// ---- dv/oms_up_model.sv ----
// Purpose: upstream framer model feeding the maintenance block
// Assumes: 16-byte frames, STAT pulse every 8 bytes
// Notes: all outputs move on the falling edge
`timescale 1ns/1ps
module oms_up_model
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] statCode,
   output logic [7:0] inData,
   output logic inValid,
   output logic inFaOh,
   output logic inOtuOh,
   output logic statValid,
   output logic [2:0] pmStat
);
   logic [7:0] cnt_reg;
   always_ff @(negedge clk or negedge arst_n)
      if (!arst_n)
         cnt_reg <= 8'h00;
      else
         cnt_reg <= cnt_reg + 8'h01;
   assign inData = cnt_reg ^ 8'hA5;
   assign inValid = arst_n;
   assign inFaOh = cnt_reg[3:0] == 4'h0;
   assign inOtuOh = cnt_reg[3:0] == 4'h1;
   assign statValid = arst_n && cnt_reg[2:0] == 3'h7;
   // Stale field value is inverted between pulses
   assign pmStat = statValid ? statCode : ~statCode;
endmodule

// ---- dv/oms_maint_props.sv ----
// Purpose: port checker for the maintenance block
// Assumes: one clock domain
// Notes: STAT pulses eight cycles apart
`timescale 1ns/1ps
module oms_maint_props
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] inData,
   input wire logic inValid,
   input wire logic inFaOh,
   input wire logic inOtuOh,
   input wire logic isCn,
   input wire logic otuTerminated,
   input wire logic upstreamDefect,
   input wire logic serverFdi,
   input wire logic notConnected,
   input wire logic adminLock,
   input wire logic useGenericAis,
   input wire logic pmiIn,
   input wire logic statValid,
   input wire logic [2:0] pmStat,
   input wire logic [7:0] outData,
   input wire logic [2:0] modeOut,
   input wire logic aisDet,
   input wire logic ociDet,
   input wire logic lckDet,
   input wire logic losDefect
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic pay;
   logic calm;
   assign pay = inValid && !inFaOh && !inOtuOh;
   assign calm = !serverFdi && !upstreamDefect && !useGenericAis;
   sequence s_stat3(logic [2:0] c);
      statValid && pmStat == c ##1 !statValid [*7] ##1
      statValid && pmStat == c ##1 !statValid [*7] ##1
      statValid && pmStat == c;
   endsequence
   a_lck_fill: assert property (
      pay && calm && adminLock |=> outData == oms_pkg::LCK_BYTE)
      else $error("lock fill wrong");
   a_oci_fill: assert property (
      pay && calm && !adminLock && notConnected && !isCn
      |=> outData == oms_pkg::OCI_BYTE) else $error("oci fill wrong");
   a_ais_fill: assert property (
      pay && upstreamDefect && !isCn |=> outData == 8'hFF)
      else $error("ais fill wrong");
   a_fa_kept: assert property (
      inValid && inFaOh |=> outData == $past(inData))
      else $error("frame alignment byte altered");
   a_otuc_ais: assert property (
      inValid && !inFaOh && isCn && serverFdi && !otuTerminated
      |=> outData == 8'hFF && modeOut == oms_pkg::OMS_OTUC_AIS)
      else $error("otuc ais wrong");
   a_fdi_odu: assert property (
      serverFdi && otuTerminated && !isCn
      |=> modeOut == oms_pkg::OMS_ODU_AIS) else $error("fdi mode wrong");
   a_pmi_los: assert property (pmiIn |=> !losDefect)
      else $error("los not suppressed");
   a_ais_det: assert property (
      s_stat3(oms_pkg::STAT_AIS) |-> ##2 aisDet) else $error("ais missed");
   a_oci_det: assert property (
      s_stat3(oms_pkg::STAT_OCI) ##1 !isCn |-> ##1 ociDet)
      else $error("oci missed");
   a_lck_det: assert property (
      s_stat3(oms_pkg::STAT_LCK) |-> ##2 lckDet) else $error("lck missed");
endmodule
bind oms_maint_gen_det oms_maint_props i_oms_maint_props (.clk, .arst_n,
   .inData, .inValid, .inFaOh, .inOtuOh, .isCn, .otuTerminated,
   .upstreamDefect, .serverFdi, .notConnected, .adminLock, .useGenericAis,
   .pmiIn, .statValid, .pmStat, .outData, .modeOut, .aisDet, .ociDet,
   .lckDet, .losDefect);

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the maintenance block
// Assumes: inputs change on the falling edge
// Notes: mode, LCK and OCI expectations come from package constants
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errCount++; \
   $display("unexpected %s expected %h seen %h", n, e, a); end end
module testbench;
   logic clk, arst_n, isCn, otuTerminated, upstreamDefect, serverFdi;
   logic notConnected, adminLock, useGenericAis, isOtu0, pmiIn, losIn;
   logic inValid, inFaOh, inOtuOh, statValid, outValid, signalFail;
   logic aisDet, ociDet, lckDet, otucAisDet, otukAisDet, losDefect;
   logic [2:0] statCode, pmStat, modeOut;
   logic [7:0] inData, outData;
   logic pnCheckValid, pnMatch;
   logic [0:0] instSel;
   int errCount;
   int checks;
   oms_up_model i_oms_up_model (.clk, .arst_n, .statCode, .inData,
      .inValid, .inFaOh, .inOtuOh, .statValid, .pmStat);
   oms_maint_gen_det i_oms_maint_gen_det (.clk, .arst_n, .inData, .inValid,
      .inFaOh, .inOtuOh, .isCn, .isOtu0, .otuTerminated, .upstreamDefect,
      .serverFdi, .notConnected, .adminLock, .useGenericAis, .pmiIn, .losIn,
      .instSel, .statValid, .smStat(pmStat), .pmStat,
      .tcmStat({6{pmStat}}), .pnCheckValid, .pnMatch, .outData,
      .outValid, .modeOut, .aisDet, .ociDet, .lckDet, .otucAisDet,
      .otukAisDet, .losDefect, .signalFail);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic report_and_stop();
      if (errCount == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic setc(input logic [7:0] v);
      {isCn, otuTerminated, upstreamDefect, serverFdi, notConnected,
         adminLock, useGenericAis, isOtu0} = v;
      repeat (2) @(negedge clk);
   endtask
   task automatic look(output logic fa, output logic otu,
      output logic [7:0] d);
      @(posedge clk);
      fa = inFaOh;
      otu = inOtuOh;
      d = inData;
      @(negedge clk);
   endtask
   task automatic t_fill(input logic [7:0] v, input logic [7:0] f,
      input logic [2:0] m, input bit pass, input bit otuFill);
      logic fa, otu;
      logic [7:0] d;
      setc(v);
      repeat (20)
      begin
         look(fa, otu, d);
         `CHK("mode", m, modeOut)
         `CHK("valid", 1'b1, outValid)
         if (pass || fa || (otu && !otuFill))
            `CHK("kept", d, outData)
         else
            `CHK("fill", f, outData)
      end
   endtask
   task automatic t_gais();
      logic fa, otu;
      logic [7:0] d;
      bit q[$];
      int bad;
      bit live;
      bad = 0;
      live = 1'b0;
      setc(8'h02);
      repeat (48)
      begin
         look(fa, otu, d);
         if (!fa && !otu)
            for (int i = 7; i >= 0; i--)
               q.push_back(outData[i]);
      end
      for (int n = 11; n < q.size(); n++)
      begin
         live |= q[n];
         if (q[n] !== (q[n - 9] ^ q[n - 11]))
            bad++;
      end
      `CHK("pn", 0, bad)
      `CHK("pnlive", 1'b1, live)
   endtask
   task automatic t_det(input logic [2:0] c, input logic [2:0] e);
      statCode = c;
      repeat (40) @(negedge clk);
      `CHK("det", e, {aisDet, ociDet, lckDet})
   endtask
   task automatic t_otuk();
      pnMatch = 1'b1;
      repeat (5)
      begin
         pnCheckValid = 1'b1;
         @(negedge clk);
         pnCheckValid = 1'b0;
         @(negedge clk);
      end
      `CHK("otuk", 1'b1, otukAisDet)
      pnCheckValid = 1'b1;
      pnMatch = 1'b0;
      @(negedge clk);
      pnCheckValid = 1'b0;
      @(negedge clk);
      `CHK("otuk", 1'b0, otukAisDet)
      pnMatch = 1'b1;
      setc(8'h01);
      repeat (5)
      begin
         pnCheckValid = 1'b1;
         @(negedge clk);
         pnCheckValid = 1'b0;
         @(negedge clk);
      end
      `CHK("otuk0", 1'b0, otukAisDet)
   endtask
   task automatic t_los();
      losIn = 1'b1;
      t_det(3'h0, 3'h0);
      `CHK("fail", 1'b1, signalFail)
      `CHK("los", 1'b1, losDefect)
      t_det(oms_pkg::STAT_AIS, 3'h4);
      `CHK("fail", 1'b0, signalFail)
      pmiIn = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("los", 1'b0, losDefect)
   endtask
   task automatic t_otuc();
      setc(8'h80);
      t_det(3'h0, 3'h0);
      `CHK("otuc", 1'b0, otucAisDet)
      t_det(oms_pkg::STAT_AIS, 3'h4);
      `CHK("otuc", 1'b1, otucAisDet)
   endtask
   initial
   begin
      {arst_n, losIn, pmiIn, statCode} = 6'h00;
      {pnCheckValid, pnMatch} = 2'h0;
      instSel = 1'b1;
      setc(8'h00);
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      t_fill(8'h04, oms_pkg::LCK_BYTE, oms_pkg::OMS_LCK, 0, 0);
      t_fill(8'h08, oms_pkg::OCI_BYTE, oms_pkg::OMS_OCI, 0, 0);
      t_fill(8'h88, 8'h00, oms_pkg::OMS_PASS, 1, 0);
      t_fill(8'h0C, oms_pkg::LCK_BYTE, oms_pkg::OMS_LCK, 0, 0);
      t_fill(8'h20, 8'hFF, oms_pkg::OMS_ODU_AIS, 0, 0);
      t_fill(8'h50, 8'hFF, oms_pkg::OMS_ODU_AIS, 0, 0);
      t_fill(8'h90, 8'hFF, oms_pkg::OMS_OTUC_AIS, 0, 1);
      t_fill(8'h03, 8'h00, oms_pkg::OMS_PASS, 1, 0);
      t_fill(8'hA0, 8'hFF, oms_pkg::OMS_ODU_AIS, 0, 0);
      instSel = 1'b0;
      t_fill(8'hA0, 8'h00, oms_pkg::OMS_ODU_AIS, 1, 0);
      instSel = 1'b1;
      t_gais();
      setc(8'h00);
      t_det(oms_pkg::STAT_AIS, 3'h4);
      t_det(oms_pkg::STAT_OCI, 3'h2);
      t_det(oms_pkg::STAT_LCK, 3'h1);
      t_otuk();
      t_los();
      t_otuc();
      report_and_stop();
   end
   initial
   begin
      #(25 * 3000);
      errCount++;
      report_and_stop();
   end
endmodule
